/* File: design/gfe_pkg.sv */
// Package for the pin filter and event counter block: register indices,
// field widths, reset values, timing constants, carrier structs and states.
// Assumes a 10 MHz system clock and a byte-addressed AXI4-Lite register bus.
package gfe_pkg;

  // Sizes
  localparam int PAIRS_MAX = 8;
  localparam int PIN_COUNT = 32;
  localparam int CNT_W     = 16;
  localparam int PICK_W    = 5;
  localparam int SRC_W     = 8;
  localparam int IDX_W     = 9;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;

  // Slow edge rate derived from the system clock (period rounded down)
  localparam int CLK_HZ      = 10_000_000;
  localparam int SLOW_HZ     = 32_000;
  localparam int TICK_CYCLES = CLK_HZ / SLOW_HZ;
  localparam int TICK_W      = 9;

  // Register indices; byte address is four times the index
  localparam logic [PAIRS_MAX-1:0][IDX_W-1:0] LEN_IDX =
    {9'h0d8, 9'h0d0, 9'h078, 9'h070, 9'h068, 9'h060, 9'h058, 9'h050};
  localparam logic [PAIRS_MAX-1:0][IDX_W-1:0] CNT_IDX =
    {9'h0da, 9'h0d2, 9'h07a, 9'h072, 9'h06a, 9'h062, 9'h05a, 9'h052};
  localparam logic [PAIRS_MAX-1:0][IDX_W-1:0] TALLY_IDX =
    {9'h0dc, 9'h0d4, 9'h07c, 9'h074, 9'h06c, 9'h064, 9'h05c, 9'h054};
  localparam logic [PAIRS_MAX-1:0][IDX_W-1:0] THR_IDX =
    {9'h0de, 9'h0d6, 9'h07e, 9'h076, 9'h06e, 9'h066, 9'h05e, 9'h056};
  localparam logic [PAIRS_MAX-1:0][IDX_W-1:0] SRC_IDX =
    {9'h0f7, 9'h0f6, 9'h0f5, 9'h0f4, 9'h0f3, 9'h0f2, 9'h0f1, 9'h0f0};
  localparam logic [IDX_W-1:0] IRQ_STATUS_IDX = 9'h100;
  localparam logic [IDX_W-1:0] IRQ_ENABLE_IDX = 9'h101;
  localparam logic [IDX_W-1:0] IRQ_CLEAR_IDX  = 9'h102;

  // Reset values and constants
  localparam logic [CNT_W-1:0]  CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
  localparam logic [PICK_W-1:0] SRC_RESET = 5'h00;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  // Per-pin controls arriving from the pin bank
  typedef struct packed {
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] filter_on;
    logic [PIN_COUNT-1:0] count_on;
    logic [PIN_COUNT-1:0] count_down;
  } gfe_pins_t;

  // Per-pair results
  typedef struct packed {
    logic [PAIRS_MAX-1:0] conditioned;
    logic [PAIRS_MAX-1:0] over;
  } gfe_pair_out_t;

  // Bus states
  typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} gfe_wr_state_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} gfe_rd_state_t;

endpackage

/* File: design/gfe_top.sv */
// Eight-way pin input conditioner: glitch filter plus event counter per pair,
// with source selection, threshold level outputs and an interrupt.
// Assumes synchronous pin controls and an AXI4-Lite master on aclk.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gfe_top
  import gfe_pkg::*;
#(
  parameter int PAIRS = PAIRS_MAX
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire gfe_pins_t           pins,
  output gfe_pair_out_t            pair_out,
  output logic                     irq
);

  // Elaboration check
  if (PAIRS < 1 || PAIRS > PAIRS_MAX) begin : g_bad_pairs
    $error("PAIRS must be 1 to 8");
  end

  // Storage
  logic [CNT_W-1:0]  len_reg   [PAIRS];
  logic [CNT_W-1:0]  fcnt_reg  [PAIRS];
  logic [CNT_W-1:0]  tally_reg [PAIRS];
  logic [CNT_W-1:0]  thr_reg   [PAIRS];
  logic [PICK_W-1:0] src_reg   [PAIRS];
  logic [PAIRS-1:0]  filt_reg;
  logic [PAIRS-1:0]  last_reg;
  logic [PAIRS-1:0]  cond_reg;
  logic [PAIRS-1:0]  cond_prev_reg;
  logic [PAIRS-1:0]  over_reg;
  logic [PAIRS-1:0]  over_rise;
  logic [PAIRS-1:0]  irq_status_reg;
  logic [PAIRS-1:0]  irq_enable_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick;

  // Bus state
  gfe_wr_state_t     wr_state_reg;
  gfe_rd_state_t     rd_state_reg;
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic [3:0]        wr_strb_reg;
  logic              wr_fire;
  logic [IDX_W-1:0]  wr_idx;
  logic [IDX_W-1:0]  rd_idx;
  logic              wr_ok;
  logic              rd_ok;
  logic [DATA_W-1:0] rd_word;

  // Byte-lane merge into a 16-bit register
  function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
                                               input logic [DATA_W-1:0] d,
                                               input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Mapped-index test shared by both bus paths
  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    idx_mapped = (idx == IRQ_STATUS_IDX) || (idx == IRQ_ENABLE_IDX) || (idx == IRQ_CLEAR_IDX);
    for (int p = 0; p < PAIRS; p++) begin
      if (idx == LEN_IDX[p] || idx == CNT_IDX[p] || idx == TALLY_IDX[p] ||
          idx == THR_IDX[p] || idx == SRC_IDX[p]) begin
        idx_mapped = 1'b1;
      end
    end
  endfunction

  assign wr_idx  = wr_addr_reg[IDX_W+1:2];
  assign rd_idx  = s_axi_araddr[IDX_W+1:2];
  assign wr_ok   = !wr_addr_reg[ADDR_W-1] && idx_mapped(wr_idx);
  assign rd_ok   = !s_axi_araddr[ADDR_W-1] && idx_mapped(rd_idx);
  assign wr_fire = (wr_state_reg == WR_COLLECT) && aw_held_reg && w_held_reg;

  // Slow edge generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 9'h001;
    end
  end
  assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

  // Write channel: address and data taken in either order
  assign s_axi_awready = (wr_state_reg == WR_COLLECT) && !aw_held_reg;
  assign s_axi_wready  = (wr_state_reg == WR_COLLECT) && !w_held_reg;
  assign s_axi_bvalid  = (wr_state_reg == WR_RESP);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WR_COLLECT;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      wr_addr_reg  <= '0;
      wr_data_reg  <= '0;
      wr_strb_reg  <= '0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        WR_COLLECT: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            wr_addr_reg <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg  <= 1'b1;
            wr_data_reg <= s_axi_wdata;
            wr_strb_reg <= s_axi_wstrb;
          end
          if (wr_fire) begin
            wr_state_reg <= WR_RESP;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= WR_COLLECT;
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
          end
        end
      endcase
    end
  end

  // Read word select from live registers
  always_comb begin
    rd_word = '0;
    for (int p = 0; p < PAIRS; p++) begin
      if (rd_idx == LEN_IDX[p])   rd_word = {16'h0000, len_reg[p]};
      if (rd_idx == CNT_IDX[p])   rd_word = {16'h0000, fcnt_reg[p]};
      if (rd_idx == TALLY_IDX[p]) rd_word = {16'h0000, tally_reg[p]};
      if (rd_idx == THR_IDX[p])   rd_word = {16'h0000, thr_reg[p]};
      if (rd_idx == SRC_IDX[p])   rd_word = {27'h0000000, src_reg[p]};
    end
    if (rd_idx == IRQ_STATUS_IDX) rd_word = {{(DATA_W-PAIRS){1'b0}}, irq_status_reg};
    if (rd_idx == IRQ_ENABLE_IDX) rd_word = {{(DATA_W-PAIRS){1'b0}}, irq_enable_reg};
  end

  // Read channel: one-edge snapshot keeps each read coherent
  assign s_axi_arready = (rd_state_reg == RD_IDLE);
  assign s_axi_rvalid  = (rd_state_reg == RD_DATA);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      unique case (rd_state_reg)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_reg <= RD_DATA;
            s_axi_rdata  <= rd_ok ? rd_word : '0;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
          end
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            rd_state_reg <= RD_IDLE;
          end
        end
      endcase
    end
  end

  // Per-pair filter and event counter
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    logic [PICK_W-1:0] sel;
    logic              lvl;
    logic              fon;
    logic              con;
    logic              cdn;
    logic              stable;
    logic              rise;
    logic              wr_len;
    logic              wr_cnt;
    logic              wr_tally;
    logic              wr_thr;
    logic              wr_src;

    // Source routing
    assign sel      = src_reg[p];
    assign lvl      = pins.level[sel];
    assign fon      = pins.filter_on[sel];
    assign con      = pins.count_on[sel];
    assign cdn      = pins.count_down[sel];
    assign stable   = (lvl == last_reg[p]);
    assign rise     = cond_reg[p] && !cond_prev_reg[p];
    assign wr_len   = wr_fire && !wr_addr_reg[ADDR_W-1] && (wr_idx == LEN_IDX[p]);
    assign wr_cnt   = wr_fire && !wr_addr_reg[ADDR_W-1] && (wr_idx == CNT_IDX[p]);
    assign wr_tally = wr_fire && !wr_addr_reg[ADDR_W-1] && (wr_idx == TALLY_IDX[p]);
    assign wr_thr   = wr_fire && !wr_addr_reg[ADDR_W-1] && (wr_idx == THR_IDX[p]);
    assign wr_src   = wr_fire && !wr_addr_reg[ADDR_W-1] && (wr_idx == SRC_IDX[p]);

    // Software-only settings
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        len_reg[p] <= CNT_RESET;
        thr_reg[p] <= CNT_RESET;
        src_reg[p] <= SRC_RESET;
      end else begin
        if (wr_len) len_reg[p] <= merge16(len_reg[p], wr_data_reg, wr_strb_reg);
        if (wr_thr) thr_reg[p] <= merge16(thr_reg[p], wr_data_reg, wr_strb_reg);
        if (wr_src && wr_strb_reg[0]) src_reg[p] <= wr_data_reg[PICK_W-1:0];
      end
    end

    // Glitch filter: reload on change, count slow edges, follow at zero
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        fcnt_reg[p] <= CNT_RESET;
        filt_reg[p] <= 1'b0;
        last_reg[p] <= 1'b0;
      end else begin
        last_reg[p] <= lvl;
        if (wr_cnt) begin
          fcnt_reg[p] <= merge16(fcnt_reg[p], wr_data_reg, wr_strb_reg);
        end else if (!fon || !stable) begin
          fcnt_reg[p] <= len_reg[p];
        end else if (tick && lvl != filt_reg[p] && fcnt_reg[p] != CNT_RESET) begin
          fcnt_reg[p] <= fcnt_reg[p] - CNT_ONE;
        end
        if (!fon) begin
          filt_reg[p] <= 1'b0;
        end else if (stable && fcnt_reg[p] == CNT_RESET) begin
          filt_reg[p] <= lvl;
        end
      end
    end

    // Conditioned output and event tally
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cond_reg[p]      <= 1'b0;
        cond_prev_reg[p] <= 1'b0;
        tally_reg[p]     <= CNT_RESET;
        over_reg[p]      <= 1'b0;
      end else begin
        cond_reg[p]      <= fon ? filt_reg[p] : last_reg[p];
        cond_prev_reg[p] <= cond_reg[p];
        if (wr_tally) begin
          tally_reg[p] <= merge16(tally_reg[p], wr_data_reg, wr_strb_reg);
        end else if (rise && con) begin
          tally_reg[p] <= cdn ? tally_reg[p] - CNT_ONE : tally_reg[p] + CNT_ONE;
        end
        over_reg[p] <= (tally_reg[p] > thr_reg[p]);
      end
    end
    assign over_rise[p] = (tally_reg[p] > thr_reg[p]) && !over_reg[p];

    chk_filter_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(fon) && fon && $changed(filt_reg[p]) |-> $past(fcnt_reg[p]) == CNT_RESET && $past(stable))
      else $error("filter output moved before settle count expired");
    chk_zero_pass: assert property (@(posedge aclk) disable iff (!aresetn)
      fon && len_reg[p] == CNT_RESET && !wr_cnt && !wr_len && !stable ##1
      (fon && stable && !wr_cnt && !wr_len) |=> filt_reg[p] == $past(lvl))
      else $error("zero settle length did not pass input");
    chk_count_load: assert property (@(posedge aclk) disable iff (!aresetn)
      !stable && !wr_cnt |=> fcnt_reg[p] == $past(len_reg[p]))
      else $error("filter counter not loaded from settle length");
    chk_tally_step: assert property (@(posedge aclk) disable iff (!aresetn)
      rise && con && !cdn && !wr_tally |=> tally_reg[p] == $past(tally_reg[p]) + CNT_ONE)
      else $error("tally did not step on qualifying edge");
    chk_tally_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_tally && wr_strb_reg[1:0] == 2'h3 |=> tally_reg[p] == $past(wr_data_reg[CNT_W-1:0]))
      else $error("tally write did not replace count");
    chk_over_level: assert property (@(posedge aclk) disable iff (!aresetn)
      $stable(tally_reg[p]) && $stable(thr_reg[p]) |-> over_reg[p] == (tally_reg[p] > thr_reg[p]))
      else $error("threshold level output wrong");
    chk_reset_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> tally_reg[p] == CNT_RESET && fcnt_reg[p] == CNT_RESET && src_reg[p] == SRC_RESET)
      else $error("pair registers not zero after reset");
  end

  // Interrupt status, enable and clear; a new event beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
      irq_enable_reg <= '0;
    end else begin
      if (wr_fire && !wr_addr_reg[ADDR_W-1] && wr_idx == IRQ_ENABLE_IDX && wr_strb_reg[0]) begin
        irq_enable_reg <= wr_data_reg[PAIRS-1:0];
      end
      if (wr_fire && !wr_addr_reg[ADDR_W-1] && wr_idx == IRQ_CLEAR_IDX && wr_strb_reg[0]) begin
        irq_status_reg <= (irq_status_reg & ~wr_data_reg[PAIRS-1:0]) | over_rise;
      end else begin
        irq_status_reg <= irq_status_reg | over_rise;
      end
    end
  end
  assign irq = |(irq_status_reg & irq_enable_reg);

  // Pair outputs, unused lanes held low
  always_comb begin
    pair_out = '0;
    pair_out.conditioned[PAIRS-1:0] = cond_reg;
    pair_out.over[PAIRS-1:0]        = over_reg;
  end

  chk_src_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && rd_idx >= SRC_IDX[0] && rd_idx <= SRC_IDX[PAIRS-1]
    |=> s_axi_rdata[DATA_W-1:PICK_W] == '0)
    else $error("reserved source bits read nonzero");
  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response not raised after commit");

endmodule

/* File: test/gfe_pin_model.sv */
// Pin bank model: holds level, filter enable, count enable and count
// direction for all 32 pins and presents them as the block's pin input.
// Assumes the bench updates one pin at a time just after a rising edge.
`timescale 1ns/1ps
module gfe_pin_model
  import gfe_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              set_stb,
  input  wire logic [PICK_W-1:0] set_pin,
  input  wire logic [3:0]        set_val,
  output gfe_pins_t              pins
);
  // Pins change only on a clock edge, so the block sees synchronous levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins <= '0;
    end else if (set_stb) begin
      pins.level[set_pin]      <= set_val[0];
      pins.filter_on[set_pin]  <= set_val[1];
      pins.count_on[set_pin]   <= set_val[2];
      pins.count_down[set_pin] <= set_val[3];
    end
  end
endmodule

/* File: test/gfe_top_tb.sv */
// Self-checking bench for the pin filter and event counter block.
// Assumes the pin model beside it and an AXI4-Lite master made of tasks.
`timescale 1ns/1ps
module gfe_top_tb
  import gfe_pkg::*;
;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] rd;
    logic [1:0]        rs;
  } gfe_row_t;

  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic              awvalid = 1'b0;
  logic              awready;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0]        wstrb = 4'h0;
  logic              wvalid = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              arvalid = 1'b0;
  logic              arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready = 1'b0;
  logic              set_stb = 1'b0;
  logic [PICK_W-1:0] set_pin = '0;
  logic [3:0]        set_val = 4'h0;
  gfe_pins_t         pins;
  gfe_pair_out_t     po;
  logic              irq;
  int                bad_count = 0;
  int                compares = 0;
  gfe_row_t          rows [10];
  localparam int     TK = TICK_CYCLES;

  // 10 MHz clock
  always #50 aclk = ~aclk;

  gfe_pin_model i_pins (.aclk(aclk), .aresetn(aresetn), .set_stb(set_stb), .set_pin(set_pin),
                        .set_val(set_val), .pins(pins));

  gfe_top #(.PAIRS(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pins(pins), .pair_out(po), .irq(irq));

  function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] i);
    return {1'b0, i, 2'b00};
  endfunction

  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    cmp_word("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask

  // Read: address held until taken, rready held until the answer
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    cmp_word("rdata", ed, rdata);
    cmp_word("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
  endtask

  // One pin update through the model, value bits are down, count, filter, level
  task automatic setp(input logic [PICK_W-1:0] n, input logic [3:0] v);
    @(posedge aclk);
    set_stb <= 1'b1;
    set_pin <= n;
    set_val <= v;
    @(posedge aclk);
    set_stb <= 1'b0;
  endtask

  task automatic pulse(input logic [PICK_W-1:0] n, input logic [3:0] v);
    setp(n, v | 4'h1);
    repeat (4) @(posedge aclk);
    setp(n, v & 4'he);
    repeat (4) @(posedge aclk);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog sized well above the filter waits of the sequence
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    $display("ERROR watchdog expired");
    end_sim();
  end

  initial begin
    rows = '{
      '{ba(THR_IDX[0]), 32'h0000_abcd, 32'h0000_abcd, RESP_OKAY},
      '{ba(THR_IDX[7]), 32'hffff_ffff, 32'h0000_ffff, RESP_OKAY},
      '{ba(LEN_IDX[3]), 32'h0000_ffff, 32'h0000_ffff, RESP_OKAY},
      '{ba(SRC_IDX[2]), 32'h0000_00ff, 32'h0000_001f, RESP_OKAY},
      '{ba(SRC_IDX[7]), 32'h0000_001a, 32'h0000_001a, RESP_OKAY},
      '{ba(TALLY_IDX[5]), 32'h0000_8001, 32'h0000_8001, RESP_OKAY},
      '{ba(THR_IDX[4]), 32'h0000_5a5a, 32'h0000_5a5a, RESP_OKAY},
      '{12'h800, 32'h1234_5678, 32'h0000_0000, RESP_SLVERR},
      '{ba(IRQ_STATUS_IDX), 32'h0000_00ff, 32'h0000_0020, RESP_OKAY},
      '{ba(IRQ_CLEAR_IDX), 32'h0000_00ff, 32'h0000_0000, RESP_OKAY}};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_word("pair_out", 32'h0, {16'h0, po});
    // Every register of every pair starts at zero
    for (int p = 0; p < 8; p++) begin
      rd(ba(LEN_IDX[p]), 32'h0, RESP_OKAY);
      rd(ba(CNT_IDX[p]), 32'h0, RESP_OKAY);
      rd(ba(TALLY_IDX[p]), 32'h0, RESP_OKAY);
      rd(ba(THR_IDX[p]), 32'h0, RESP_OKAY);
      rd(ba(SRC_IDX[p]), 32'h0, RESP_OKAY);
    end
    // Register table rows, back to back write then read
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].rs);
      rd(rows[i].a, rows[i].rd, rows[i].rs);
    end
    // Filter on pair 0 fed from pin 3, short settle length
    wr(ba(SRC_IDX[0]), 32'h3, RESP_OKAY);
    wr(ba(LEN_IDX[0]), 32'h2, RESP_OKAY);
    setp(5'd3, 4'b0010);
    repeat (20) @(posedge aclk);
    wr(ba(CNT_IDX[0]), 32'h1234, RESP_OKAY);
    rd(ba(CNT_IDX[0]), 32'h1234, RESP_OKAY);
    setp(5'd3, 4'b0011);
    repeat (TK / 2) @(posedge aclk);
    cmp_bit("conditioned0", 1'b0, po.conditioned[0]);
    repeat (4 * TK) @(posedge aclk);
    cmp_bit("conditioned0", 1'b1, po.conditioned[0]);
    // A glitch far shorter than one slow edge must not pass
    setp(5'd3, 4'b0010);
    repeat (5) @(posedge aclk);
    setp(5'd3, 4'b0011);
    repeat (4 * TK) @(posedge aclk);
    cmp_bit("conditioned0", 1'b1, po.conditioned[0]);
    // Zero length passes the pin straight through
    wr(ba(LEN_IDX[0]), 32'h0, RESP_OKAY);
    setp(5'd3, 4'b0010);
    repeat (6) @(posedge aclk);
    cmp_bit("conditioned0", 1'b0, po.conditioned[0]);
    // Enabling the filter on a high pin gives a low pulse first
    wr(ba(LEN_IDX[0]), 32'h2, RESP_OKAY);
    setp(5'd3, 4'b0001);
    repeat (6) @(posedge aclk);
    cmp_bit("conditioned0", 1'b1, po.conditioned[0]);
    setp(5'd3, 4'b0011);
    repeat (10) @(posedge aclk);
    cmp_bit("conditioned0", 1'b0, po.conditioned[0]);
    repeat (4 * TK) @(posedge aclk);
    cmp_bit("conditioned0", 1'b1, po.conditioned[0]);
    // Tally on pair 1 fed from pin 4, threshold 2, interrupt enabled
    wr(ba(SRC_IDX[1]), 32'h4, RESP_OKAY);
    wr(ba(THR_IDX[1]), 32'h2, RESP_OKAY);
    wr(ba(IRQ_ENABLE_IDX), 32'h2, RESP_OKAY);
    repeat (3) pulse(5'd4, 4'b0100);
    rd(ba(TALLY_IDX[1]), 32'h3, RESP_OKAY);
    cmp_bit("over1", 1'b1, po.over[1]);
    cmp_bit("irq", 1'b1, irq);
    rd(ba(IRQ_STATUS_IDX), 32'h02, RESP_OKAY);
    wr(ba(IRQ_ENABLE_IDX), 32'h0, RESP_OKAY);
    cmp_bit("irq", 1'b0, irq);
    wr(ba(IRQ_ENABLE_IDX), 32'h2, RESP_OKAY);
    cmp_bit("irq", 1'b1, irq);
    wr(ba(IRQ_CLEAR_IDX), 32'h2, RESP_OKAY);
    rd(ba(IRQ_STATUS_IDX), 32'h00, RESP_OKAY);
    cmp_bit("irq", 1'b0, irq);
    // Counting down drops the level output, then wrap below zero
    pulse(5'd4, 4'b1100);
    rd(ba(TALLY_IDX[1]), 32'h2, RESP_OKAY);
    cmp_bit("over1", 1'b0, po.over[1]);
    wr(ba(TALLY_IDX[1]), 32'h0, RESP_OKAY);
    pulse(5'd4, 4'b1100);
    rd(ba(TALLY_IDX[1]), 32'hffff, RESP_OKAY);
    cmp_bit("over1", 1'b1, po.over[1]);
    // Second reset in mid-run clears everything again
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_word("pair_out", 32'h0, {16'h0, po});
    cmp_bit("irq", 1'b0, irq);
    rd(ba(TALLY_IDX[1]), 32'h0, RESP_OKAY);
    rd(ba(SRC_IDX[7]), 32'h0, RESP_OKAY);
    end_sim();
  end
endmodule
